// file: design/flash_seq_pkg.sv
// Purpose: Shared constants for the serial flash instruction sequencer.
// Assumes: 50 MHz system clock; serial pins sampled synchronously.
// Notes: Time figures are in nanoseconds; RESUME_BUSY_CYC derives from them, the other counts are given in cycles.
package flash_seq_pkg;

  // --------------------------------------------------------------
  // Clock and timing
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESUME_BUSY_NS = 200;
  localparam int RESUME_BUSY_CYC = RESUME_BUSY_NS / CLK_PERIOD_NS;
  localparam int FULL_ERASE_CYC_DEF = 100000;
  localparam int PAUSE_LATENCY_CYC_DEF = 1000;
  localparam int SLEEP_ENTRY_CYC_DEF = 150;
  localparam int WAKE_CYC_DEF = 150;
  localparam int WAKE_ID_CYC_DEF = 90;
  localparam int PROGRAM_CYC_DEF = 20000;
  localparam int SECTOR_ERASE_CYC_DEF = 50000;

  // --------------------------------------------------------------
  // Opcodes
  // --------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_FULL_ERASE_A = 8'hC7;
  localparam logic [7:0] OP_FULL_ERASE_B = 8'h60;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
  localparam logic [7:0] OP_SECREG_ERASE = 8'h44;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_QUAD_PROGRAM = 8'h32;
  localparam logic [7:0] OP_SECREG_PROGRAM = 8'h42;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE_ID = 8'hAB;
  localparam logic [7:0] OP_MFR_DEV_ID = 8'h90;

  // --------------------------------------------------------------
  // Values and field positions
  // --------------------------------------------------------------
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_WEL_BIT = 1;
  localparam int STATUS_PAUSED_BIT = 7;
  localparam int ID_DUMMY_BYTES = 3;
  localparam int MFR_ADDR_BYTES = 3;

  // Kind of self-timed operation in progress.
  typedef enum logic [1:0] {
    OPK_NONE = 2'h0,
    OPK_ERASE = 2'h1,
    OPK_PROGRAM = 2'h3,
    OPK_FULL = 2'h2
  } op_kind_type;

endpackage : flash_seq_pkg

// file: design/flash_shift_in.sv
// Purpose: Serial byte receiver on a sampled host clock.
// Assumes: Serial clock and data are synchronous to mclk_in.
// Notes: Reports each completed byte and the bit count within a frame.
module flash_shift_in
  import flash_seq_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic cs_n_in,
  input wire logic sclk_rise_in,
  input wire logic sdi_in,
  output logic byte_done_out,
  output logic [7:0] byte_out,
  output logic [2:0] bit_cnt_out
);

  logic [6:0] shift_ff;
  logic [2:0] cnt_ff;
  logic [7:0] nxt_byte;
  assign nxt_byte = {shift_ff, sdi_in};
  assign bit_cnt_out = cnt_ff;

  // --------------------------------------------------------------
  // Bit gathering; the bit count is cleared whenever chip select is high.
  // --------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_ff <= 7'h00;
      cnt_ff <= 3'h0;
      byte_done_out <= 1'b0;
      byte_out <= 8'h00;
    end else begin
      byte_done_out <= 1'b0;
      if (cs_n_in) begin
        cnt_ff <= 3'h0;
      end else if (sclk_rise_in) begin
        shift_ff <= nxt_byte[6:0];
        cnt_ff <= cnt_ff + 3'h1;
        if (cnt_ff == 3'h7) begin
          byte_done_out <= 1'b1;
          byte_out <= nxt_byte;
        end
      end
    end
  end

endmodule // flash_shift_in

// file: design/flash_op_timer.sv
// Purpose: Down counter for self-timed operations.
// Assumes: Load wins over counting; pause freezes the count.
// Notes: Done pulses one cycle when the count reaches zero.
module flash_op_timer #(
  parameter int WIDTH = 24
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [WIDTH-1:0] load_val_in,
  input wire logic run_in,
  output logic done_out
);

  logic [WIDTH-1:0] cnt_ff;

  // Counts down while running and fires once at one.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (load_in) begin
        cnt_ff <= load_val_in;
      end else if (run_in && cnt_ff != '0) begin
        cnt_ff <= cnt_ff - 1'b1;
        done_out <= (cnt_ff == {{(WIDTH-1){1'b0}}, 1'b1});
      end
    end
  end

endmodule // flash_op_timer

// file: design/flash_seq.sv
// Purpose: Instruction sequencer for full erase, suspend/resume, sleep and ID reads.
// Assumes: Serial pins synchronous to mclk_in; power-on is the only reset.
// Notes: Memory array is external; erase_all_out requests it be set to all ones.
//
// Summary of operation
// - Opcodes C7h or 60h erase the whole array to FFh.
// - Full erase refused unless write_enable_latch is set.
// - Full erase runs only if chip select rises right after bit eight.
// - During full erase busy reads one; afterwards busy and latch clear.
// - Full erase refused when any protection setting covers a page.
// - Suspend accepted only when not paused, busy, in sector/block erase or program.
// - Suspend ignored during full erase.
// - Erase suspended: status write and all erases rejected.
// - Program suspended: status write and all programs rejected.
// - Accepted suspend sets paused_flag at once, clears busy within pause_latency.
// - Resume only when paused and idle; clears pause, busy within 200ns.
// - Power loss clears paused_flag; later resume is ignored.
// - Sleep opcode enters low power after sleep_entry_time if timing met.
// - Asleep, only the wake/identify opcode is recognised.
// - Power-up always starts awake.
// - Wake needs chip select high for wake_time before normal operation.
// - Wake/identify with three dummy bytes streams device id repeatedly, only when already awake.
// - Wake with id read needs wake_with_id_time before normal operation.
// - Wake/identify ignored while busy.
// - 90h returns manufacturer then device, swapped for address one.
module flash_seq
  import flash_seq_pkg::*;
#(
  parameter int FULL_ERASE_CYC = FULL_ERASE_CYC_DEF,
  parameter int PAUSE_LATENCY_CYC = PAUSE_LATENCY_CYC_DEF,
  parameter int PROGRAM_CYC = PROGRAM_CYC_DEF,
  parameter int SECTOR_ERASE_CYC = SECTOR_ERASE_CYC_DEF,
  parameter int SLEEP_ENTRY_CYC = SLEEP_ENTRY_CYC_DEF,
  parameter int WAKE_CYC = WAKE_CYC_DEF,
  parameter int WAKE_ID_CYC = WAKE_ID_CYC_DEF,
  parameter logic [7:0] MFR_ID = 8'h5A,
  parameter logic [7:0] DEV_ID = 8'h12
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic sdi_in,
  input wire logic protect_invert_in,
  input wire logic small_unit_protect_in,
  input wire logic top_bottom_select_in,
  input wire logic [2:0] block_protect_bits_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  output logic busy_out,
  output logic write_enable_latch_out,
  output logic paused_flag_out,
  output logic asleep_out,
  output logic erase_all_out,
  output logic [7:0] erase_value_out
);

  // MFR_ID and DEV_ID defaults are arbitrary values.
  localparam int TW = 24;

  // --------------------------------------------------------------
  // Front end: serial clock edges and byte receiver.
  // --------------------------------------------------------------
  logic sclk_ff;
  logic cs_n_ff;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [2:0] bit_cnt;

  assign sclk_rise = sclk_in && !sclk_ff;
  assign sclk_fall = !sclk_in && sclk_ff;
  assign cs_rise = cs_n_in && !cs_n_ff;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_ff <= 1'b0;
      cs_n_ff <= 1'b1;
    end else begin
      sclk_ff <= sclk_in;
      cs_n_ff <= cs_n_in;
    end
  end

  flash_shift_in u_rx (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .cs_n_in(cs_n_in),
    .sclk_rise_in(sclk_rise),
    .sdi_in(sdi_in),
    .byte_done_out(byte_done),
    .byte_out(rx_byte),
    .bit_cnt_out(bit_cnt)
  );

  // --------------------------------------------------------------
  // Frame tracking: opcode, byte count, clean end of frame.
  // --------------------------------------------------------------
  logic [7:0] opcode_ff;
  logic [2:0] nbytes_ff;
  logic addr_one_ff;
  logic [7:0] tx_ff;
  logic tx_on_ff;
  logic id_sel_ff;
  logic [2:0] tx_bit_ff;

  logic busy_ff;
  logic wel_ff;
  logic paused_ff;
  logic asleep_ff;
  logic erase_all_ff;
  op_kind_type kind_ff;

  // Frame is clean when exactly the opcode byte was shifted.
  logic one_byte_end;
  assign one_byte_end = cs_rise && nbytes_ff == 3'h1 && bit_cnt == 3'h0;

  // Instruction classes.
  function automatic logic is_erase(input logic [7:0] op);
    is_erase = op == OP_SECTOR_ERASE || op == OP_BLOCK32_ERASE
      || op == OP_BLOCK64_ERASE || op == OP_SECREG_ERASE
      || op == OP_FULL_ERASE_A || op == OP_FULL_ERASE_B;
  endfunction

  function automatic logic is_program(input logic [7:0] op);
    is_program = op == OP_PROGRAM || op == OP_QUAD_PROGRAM || op == OP_SECREG_PROGRAM;
  endfunction

  // Any protection setting covering a page blocks a full erase.
  logic any_protect;
  assign any_protect = (block_protect_bits_in != 3'h0) || protect_invert_in
    || small_unit_protect_in || top_bottom_select_in;

  // Wake sequence state: awake, entering sleep, sleeping, or waking.
  typedef enum logic [1:0] {
    PW_AWAKE = 2'h0,
    PW_ENTER = 2'h1,
    PW_SLEEP = 2'h3,
    PW_WAKE = 2'h2
  } pwr_state_type;
  pwr_state_type pwr_ff;
  pwr_state_type nxt_pwr;
  logic [TW-1:0] pwr_cnt_ff;

  logic awake;
  assign awake = pwr_ff == PW_AWAKE;

  // Instruction at frame end, decided on the stored opcode.
  logic op_full;
  logic op_susp;
  logic op_res;
  logic op_sleep;
  logic op_wake;
  logic op_wren;
  logic op_start;
  logic blocked_by_pause;

  assign blocked_by_pause = paused_ff && (opcode_ff == OP_WRITE_STATUS
    || (kind_ff == OPK_ERASE && is_erase(opcode_ff))
    || (kind_ff == OPK_PROGRAM && is_program(opcode_ff)));
  assign op_full = awake && one_byte_end && !busy_ff && wel_ff && !any_protect
    && !blocked_by_pause && !paused_ff
    && (opcode_ff == OP_FULL_ERASE_A || opcode_ff == OP_FULL_ERASE_B);
  assign op_susp = awake && cs_rise && opcode_ff == OP_SUSPEND && busy_ff
    && !paused_ff && kind_ff != OPK_FULL;
  assign op_res = awake && cs_rise && opcode_ff == OP_RESUME && paused_ff
    && !busy_ff;
  assign op_sleep = awake && one_byte_end && opcode_ff == OP_SLEEP && !busy_ff;
  assign op_wake = cs_rise && opcode_ff == OP_WAKE_ID && !busy_ff
    && pwr_ff == PW_SLEEP;
  assign op_wren = awake && one_byte_end && opcode_ff == OP_WRITE_ENABLE && !busy_ff;
  // Sector/block erase and page program start after a full address.
  assign op_start = awake && cs_rise && !busy_ff && wel_ff && !blocked_by_pause
    && !paused_ff && nbytes_ff >= 3'h4 && bit_cnt == 3'h0
    && (is_program(opcode_ff) || (is_erase(opcode_ff) && opcode_ff != OP_FULL_ERASE_A
    && opcode_ff != OP_FULL_ERASE_B));

  // Frame bookkeeping and address of the manufacturer id read.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      opcode_ff <= 8'h00;
      nbytes_ff <= 3'h0;
      addr_one_ff <= 1'b0;
    end else if (cs_n_in) begin
      nbytes_ff <= cs_rise ? nbytes_ff : 3'h0;
    end else if (byte_done) begin
      if (nbytes_ff == 3'h0) begin
        opcode_ff <= rx_byte;
      end
      if (nbytes_ff == 3'(MFR_ADDR_BYTES)) begin
        addr_one_ff <= rx_byte[0];
      end
      if (nbytes_ff != 3'h7) begin
        nbytes_ff <= nbytes_ff + 3'h1;
      end
    end
  end

  // --------------------------------------------------------------
  // Self-timed operation timer.
  // --------------------------------------------------------------
  logic tmr_load;
  logic [TW-1:0] tmr_val;
  logic tmr_done;
  logic susp_pend_ff;
  logic [TW-1:0] susp_cnt_ff;
  logic [TW-1:0] res_cnt_ff;

  assign tmr_load = op_full || op_start;
  assign tmr_val = op_full ? TW'(FULL_ERASE_CYC)
    : is_program(opcode_ff) ? TW'(PROGRAM_CYC) : TW'(SECTOR_ERASE_CYC);

  flash_op_timer #(
    .WIDTH(TW)
  ) u_tmr (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .load_in(tmr_load),
    .load_val_in(tmr_val),
    .run_in(busy_ff && !paused_ff),
    .done_out(tmr_done)
  );

  // --------------------------------------------------------------
  // Status flags: busy, write enable latch, paused.
  // --------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_ff <= 1'b0;
      wel_ff <= 1'b0;
      paused_ff <= 1'b0;
      kind_ff <= OPK_NONE;
      susp_pend_ff <= 1'b0;
      susp_cnt_ff <= '0;
      res_cnt_ff <= '0;
      erase_all_ff <= 1'b0;
    end else begin
      erase_all_ff <= 1'b0;
      if (op_wren) begin
        wel_ff <= 1'b1;
      end
      if (tmr_load) begin
        busy_ff <= 1'b1;
        kind_ff <= op_full ? OPK_FULL : is_program(opcode_ff) ? OPK_PROGRAM : OPK_ERASE;
        erase_all_ff <= op_full;
      end else if (tmr_done && !paused_ff) begin
        busy_ff <= 1'b0;
        wel_ff <= 1'b0;
        kind_ff <= OPK_NONE;
      end
      // Suspend: flag at once, busy drops after the latency count.
      if (op_susp) begin
        paused_ff <= 1'b1;
        susp_pend_ff <= 1'b1;
        susp_cnt_ff <= TW'(PAUSE_LATENCY_CYC);
      end else if (susp_pend_ff) begin
        susp_cnt_ff <= susp_cnt_ff - 1'b1;
        if (susp_cnt_ff == TW'(1)) begin
          busy_ff <= 1'b0;
          susp_pend_ff <= 1'b0;
        end
      end
      // Resume: clear pause now, busy returns within 200 ns.
      if (op_res) begin
        paused_ff <= 1'b0;
        res_cnt_ff <= TW'(RESUME_BUSY_CYC);
      end else if (res_cnt_ff != '0) begin
        res_cnt_ff <= res_cnt_ff - 1'b1;
        if (res_cnt_ff == TW'(1)) begin
          busy_ff <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Low-power state machine.
  // --------------------------------------------------------------
  always_comb begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      PW_AWAKE: if (op_sleep) nxt_pwr = PW_ENTER;
      PW_ENTER: if (pwr_cnt_ff == TW'(1)) nxt_pwr = PW_SLEEP;
      PW_SLEEP: if (op_wake) nxt_pwr = PW_WAKE;
      PW_WAKE: if (pwr_cnt_ff == TW'(1)) nxt_pwr = PW_AWAKE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwr_ff <= PW_AWAKE;
      pwr_cnt_ff <= '0;
    end else begin
      pwr_ff <= nxt_pwr;
      if (op_sleep) begin
        pwr_cnt_ff <= TW'(SLEEP_ENTRY_CYC);
      end else if (op_wake) begin
        pwr_cnt_ff <= (nbytes_ff > 3'h1) ? TW'(WAKE_ID_CYC) : TW'(WAKE_CYC);
      end else if (pwr_cnt_ff != '0) begin
        pwr_cnt_ff <= pwr_cnt_ff - 1'b1;
      end
    end
  end

  // --------------------------------------------------------------
  // Identifier output shifter on falling serial clock edges.
  // --------------------------------------------------------------
  logic id_start;
  logic id_mfr;
  assign id_start = !cs_n_in && byte_done && !busy_ff && !tx_on_ff
    && ((opcode_ff == OP_WAKE_ID && awake && nbytes_ff == 3'(ID_DUMMY_BYTES))
    || (opcode_ff == OP_MFR_DEV_ID && awake && nbytes_ff == 3'(MFR_ADDR_BYTES)));
  assign id_mfr = (opcode_ff == OP_MFR_DEV_ID) && (id_sel_ff == 1'b0);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_ff <= 8'h00;
      tx_on_ff <= 1'b0;
      id_sel_ff <= 1'b0;
      tx_bit_ff <= 3'h0;
      sdo_out <= 1'b0;
      sdo_oe_out <= 1'b0;
    end else if (cs_n_in) begin
      tx_on_ff <= 1'b0;
      sdo_oe_out <= 1'b0;
    end else if (id_start) begin
      tx_on_ff <= 1'b1;
      tx_bit_ff <= 3'h0;
      id_sel_ff <= (opcode_ff == OP_MFR_DEV_ID) ? rx_byte[0] : 1'b0;
      tx_ff <= (opcode_ff == OP_MFR_DEV_ID && !rx_byte[0]) ? MFR_ID : DEV_ID;
    end else if (tx_on_ff && sclk_fall) begin
      sdo_oe_out <= 1'b1;
      sdo_out <= tx_ff[3'h7 - tx_bit_ff];
      tx_bit_ff <= tx_bit_ff + 3'h1;
      if (tx_bit_ff == 3'h7) begin
        // Alternate for the 90h read; repeat device id for ABh.
        id_sel_ff <= (opcode_ff == OP_MFR_DEV_ID) ? !id_sel_ff : 1'b0;
        tx_ff <= (opcode_ff == OP_MFR_DEV_ID && id_mfr) ? DEV_ID
          : (opcode_ff == OP_MFR_DEV_ID) ? MFR_ID : DEV_ID;
      end
    end
  end

  // --------------------------------------------------------------
  // Registered outputs.
  // --------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_out <= 1'b0;
      write_enable_latch_out <= 1'b0;
      paused_flag_out <= 1'b0;
      asleep_out <= 1'b0;
      erase_all_out <= 1'b0;
      erase_value_out <= ERASED_BYTE;
    end else begin
      busy_out <= busy_ff;
      write_enable_latch_out <= wel_ff;
      paused_flag_out <= paused_ff;
      asleep_out <= pwr_ff == PW_SLEEP;
      erase_all_out <= erase_all_ff;
      erase_value_out <= ERASED_BYTE;
    end
  end

endmodule // flash_seq

// file: dv/spi_host_model.sv
// Purpose: Behavioural serial host that frames instructions for the flash sequencer.
// Assumes: Mode 0 framing; the serial clock idles low and stands still between frames.
// Notes: Each serial clock phase lasts several system clocks so the sampler sees every edge.
module spi_host_model (
  input wire logic mclk_in,
  input wire logic sdo_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic sdi_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels at time zero.
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end

  // Sends nb bits MSB first, then clocks rb bits back; data moves with the falling clock and once more as chip select rises.
  task automatic frame(input logic [39:0] d, input int nb, input int rb, output logic [15:0] rd);
    int i;
    rd = 16'h0000;
    @(posedge mclk_in) cs_n_out <= 1'b0;
    for (i = 0; i < nb + rb; i++) begin
      @(posedge mclk_in) sclk_out <= 1'b0;
      sdi_out <= (i < nb) ? d[nb-1-i] : ~sdi_out;
      repeat (4) @(posedge mclk_in);
      if (i >= nb) rd = {rd[14:0], sdo_in};
      sclk_out <= 1'b1;
      repeat (3) @(posedge mclk_in);
    end
    @(posedge mclk_in) sclk_out <= 1'b0;
    @(posedge mclk_in) cs_n_out <= 1'b1;
    sdi_out <= ~sdi_out; // Released line shows the inverse, never a stale bit.
  endtask
endmodule // spi_host_model

// file: dv/flash_seq_assertions.sv
// Purpose: Port-level checks on the flash sequencer.
// Assumes: Single clock domain with asynchronous active-low reset.
// Notes: Attached to every sequencer instance through the bind below.
module flash_seq_checker
  import flash_seq_pkg::*;
#(
  parameter int PAUSE_LATENCY_CYC = PAUSE_LATENCY_CYC_DEF
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic cs_n_in,
  input wire logic protect_invert_in,
  input wire logic small_unit_protect_in,
  input wire logic top_bottom_select_in,
  input wire logic [2:0] block_protect_bits_in,
  input wire logic sdo_oe_out,
  input wire logic busy_out,
  input wire logic write_enable_latch_out,
  input wire logic paused_flag_out,
  input wire logic asleep_out,
  input wire logic erase_all_out,
  input wire logic [7:0] erase_value_out
);
  // Bounds allow for the registered output stage.
  localparam int PAUSE_MAX = PAUSE_LATENCY_CYC + 3;
  localparam int RESUME_MAX = RESUME_BUSY_CYC + 3;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_cs_idle;
    cs_n_in ##1 cs_n_in;
  endsequence
  sequence s_pause_taken;
    $rose(paused_flag_out);
  endsequence

  property p_erase_value; erase_all_out |-> erase_value_out == ERASED_BYTE; endproperty
  property p_erase_pulse; erase_all_out |=> !erase_all_out; endproperty
  property p_erase_wel;
    erase_all_out |-> write_enable_latch_out || $past(write_enable_latch_out);
  endproperty
  property p_erase_prot;
    erase_all_out |-> !(protect_invert_in | small_unit_protect_in | top_bottom_select_in
      | (|block_protect_bits_in));
  endproperty
  property p_erase_busy; erase_all_out |-> ##[0:2] busy_out; endproperty
  property p_done_clears;
    $fell(busy_out) && !paused_flag_out |-> ##[0:1] !write_enable_latch_out;
  endproperty
  property p_pause_needs_busy; s_pause_taken |-> $past(busy_out); endproperty
  property p_pause_latency; s_pause_taken |-> ##[0:PAUSE_MAX] !busy_out; endproperty
  property p_resume_busy; $fell(paused_flag_out) |-> ##[0:RESUME_MAX] busy_out; endproperty
  property p_sleep_idle; asleep_out |-> !busy_out; endproperty
  property p_oe_idle; s_cs_idle |=> !sdo_oe_out; endproperty

  a_erase_value: assert property (p_erase_value) else $error("erase value wrong");
  a_erase_pulse: assert property (p_erase_pulse) else $error("erase pulse long");
  a_erase_wel: assert property (p_erase_wel) else $error("erase without latch");
  a_erase_prot: assert property (p_erase_prot) else $error("erase while protected");
  a_erase_busy: assert property (p_erase_busy) else $error("erase without busy");
  a_done_clears: assert property (p_done_clears) else $error("latch kept after op");
  a_pause_needs_busy: assert property (p_pause_needs_busy) else $error("idle pause");
  a_pause_latency: assert property (p_pause_latency) else $error("busy after pause");
  a_resume_busy: assert property (p_resume_busy) else $error("resume no busy");
  a_sleep_idle: assert property (p_sleep_idle) else $error("busy while asleep");
  a_oe_idle: assert property (p_oe_idle) else $error("drive outside frame");
endmodule // flash_seq_checker

bind flash_seq flash_seq_checker #(.PAUSE_LATENCY_CYC(PAUSE_LATENCY_CYC)) u_flash_seq_checker (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in),
  .protect_invert_in(protect_invert_in), .small_unit_protect_in(small_unit_protect_in),
  .top_bottom_select_in(top_bottom_select_in), .block_protect_bits_in(block_protect_bits_in),
  .sdo_oe_out(sdo_oe_out), .busy_out(busy_out), .write_enable_latch_out(write_enable_latch_out),
  .paused_flag_out(paused_flag_out), .asleep_out(asleep_out), .erase_all_out(erase_all_out),
  .erase_value_out(erase_value_out));

// file: dv/test_spi_flash_erase_suspend_sleep_id.sv
// Purpose: Self-checking bench for the flash sequencer.
// Assumes: Shortened operation times set through the design parameters.
// Notes: Notes queue holds {kind, value}; kind 1 compares read data, kind 0 the flags.
module test_spi_flash_erase_suspend_sleep_id;
  import flash_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MFR = 8'h3C; // Arbitrary maker code.
  localparam logic [7:0] DEV = 8'hA5; // Arbitrary device code.
  logic mclk, rst_n, cs_n, sclk, sdi, sdo, oe, busy, write_enable_latch, paused, asleep, erase_all, chk_req;
  logic [5:0] prot;
  logic [7:0] erase_val;
  logic [3:0] erase_cnt;
  logic [15:0] rd;
  logic [16:0] notes[$];
  int fail_count, n_tests, cycles, i;

  localparam int T_OP = 2000; // Shortened self-timed operation length.
  flash_seq #(.FULL_ERASE_CYC(T_OP), .PAUSE_LATENCY_CYC(5), .PROGRAM_CYC(T_OP),
    .SECTOR_ERASE_CYC(T_OP), .SLEEP_ENTRY_CYC(5), .WAKE_CYC(120), .WAKE_ID_CYC(20),
    .MFR_ID(MFR), .DEV_ID(DEV)) u_flash_seq (
    .mclk_in(mclk), .rst_n_in(rst_n), .cs_n_in(cs_n), .sclk_in(sclk), .sdi_in(sdi),
    .protect_invert_in(prot[5]), .small_unit_protect_in(prot[4]),
    .top_bottom_select_in(prot[3]), .block_protect_bits_in(prot[2:0]),
    .sdo_out(sdo), .sdo_oe_out(oe), .busy_out(busy), .write_enable_latch_out(write_enable_latch),
    .paused_flag_out(paused), .asleep_out(asleep), .erase_all_out(erase_all),
    .erase_value_out(erase_val));
  spi_host_model u_spi_host_model (.mclk_in(mclk), .sdo_in(sdo), .cs_n_out(cs_n),
    .sclk_out(sclk), .sdi_out(sdi));

  // Clock source.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_tests++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic end_of_test;
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Monitor: counts erase pulses, compares oldest note on request, and cuts hangs short.
  always @(posedge mclk) begin
    logic [16:0] n;
    cycles++;
    if (erase_all === 1'b1) erase_cnt <= erase_cnt + 4'h1;
    if (chk_req) begin
      n = notes.pop_front();
      check(n[16] ? rd : {erase_val, erase_cnt, busy, write_enable_latch, paused, asleep}, n[15:0]);
    end
    if (cycles == 40000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic note(input logic [16:0] n);
    notes.push_back(n);
    chk_req <= 1'b1;
    @(posedge mclk) chk_req <= 1'b0;
    @(posedge mclk);
  endtask

  // Flags nibble is busy, latch, paused, asleep.
  task automatic flags(input logic [3:0] ec, input logic [3:0] f);
    note({1'b0, 8'hFF, ec, f});
  endtask

  task automatic cmd(input logic [39:0] d, input int nb, input int w);
    u_spi_host_model.frame(d, nb, 0, rd);
    repeat (w) @(posedge mclk);
  endtask

  task automatic wait_idle;
    int k;
    for (k = 0; k < 5000 && busy !== 1'b0; k++) @(posedge mclk);
    repeat (4) @(posedge mclk);
  endtask

  // Main sequence.
  initial begin
    void'($urandom(12568));
    rst_n = 1'b0;
    chk_req = 1'b0;
    prot = 6'h00;
    erase_cnt = 4'h0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    flags(4'h0, 4'h0);
    cmd(40'(OP_FULL_ERASE_A), 8, 6);
    flags(4'h0, 4'h0);
    cmd(40'(OP_WRITE_ENABLE), 8, 6);
    cmd({31'h0, OP_FULL_ERASE_A, 1'b0}, 9, 6);
    flags(4'h0, 4'h4);
    for (i = 0; i < 6; i++) begin
      prot <= 6'(1 << i) | 6'($urandom);
      cmd(40'(OP_FULL_ERASE_B), 8, 6);
      flags(4'h0, 4'h4);
    end
    prot <= 6'h00;
    for (i = 0; i < 2; i++) begin
      cmd(40'(OP_WRITE_ENABLE), 8, 6);
      cmd(40'(i ? OP_FULL_ERASE_B : OP_FULL_ERASE_A), 8, 6);
      flags(4'(i + 1), 4'hC);
      cmd(40'(OP_SUSPEND), 8, 12);
      cmd(40'(OP_SLEEP), 8, 12);
      flags(4'(i + 1), 4'hC);
      wait_idle();
      flags(4'(i + 1), 4'h0);
    end
    cmd(40'(OP_WRITE_ENABLE), 8, 6);
    cmd({8'h00, OP_SECTOR_ERASE, 24'h001000}, 32, 6);
    cmd(40'(OP_SUSPEND), 8, 12);
    flags(4'h2, 4'h6);
    cmd(40'(OP_FULL_ERASE_A), 8, 6);
    cmd({8'h00, OP_SECTOR_ERASE, 24'h002000}, 32, 6);
    flags(4'h2, 4'h6);
    cmd(40'(OP_RESUME), 8, 16);
    flags(4'h2, 4'hC);
    cmd(40'(OP_RESUME), 8, 16);
    flags(4'h2, 4'hC);
    wait_idle();
    cmd(40'(OP_WRITE_ENABLE), 8, 6);
    cmd({OP_PROGRAM, 24'h000100, 8'h5A}, 40, 6);
    cmd(40'(OP_SUSPEND), 8, 12);
    cmd({OP_PROGRAM, 24'h000200, 8'hA5}, 40, 6);
    flags(4'h2, 4'h6);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    cmd(40'(OP_RESUME), 8, 16);
    flags(4'h2, 4'h0);
    cmd(40'(OP_SLEEP), 8, 12);
    flags(4'h2, 4'h1);
    cmd(40'(OP_WRITE_ENABLE), 8, 6);
    flags(4'h2, 4'h1);
    cmd(40'(OP_WAKE_ID), 8, 2);
    cmd(40'(OP_WRITE_ENABLE), 8, 2);
    flags(4'h2, 4'h0);
    repeat (60) @(posedge mclk);
    flags(4'h2, 4'h0);
    cmd({31'h0, OP_SLEEP, 1'b1}, 9, 12);
    flags(4'h2, 4'h0);
    cmd(40'(OP_SLEEP), 8, 12);
    u_spi_host_model.frame({8'h00, OP_WAKE_ID, 24'h000000}, 32, 16, rd);
    repeat (30) @(posedge mclk);
    flags(4'h2, 4'h0);
    u_spi_host_model.frame({8'h00, OP_WAKE_ID, 24'h000000}, 32, 16, rd);
    note({1'b1, DEV, DEV});
    for (i = 0; i < 2; i++) begin
      u_spi_host_model.frame({8'h00, OP_MFR_DEV_ID, 23'h0, i[0]}, 32, 16, rd);
      note({1'b1, i[0] ? {DEV, MFR} : {MFR, DEV}});
    end
    end_of_test();
  end
endmodule // test_spi_flash_erase_suspend_sleep_id
